// [bench/itl_sw_model.sv]
/*
  Software side model: sets up the legacy execution environment.
  Assumes the bench drives the transition requests themselves.
*/
`timescale 1ns/1ps
`default_nettype none
module itl_sw_model #(
  parameter logic [63:0] GDT_VAL  = 64'h0000_0000_0001_2340,
  parameter logic [63:0] LDT_VAL  = 64'h0000_0000_0005_6780,
  parameter logic [31:0] CODE_VAL = 32'h0040_0000
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  output logic [63:0]      gr_thirty_in,
  output logic [63:0]      gr_thirty_one_in,
  output logic [31:0]      code_segment_app_register
);
  // Descriptor table and code segment values loaded while sys_rst is high, then held
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      gr_thirty_in              <= GDT_VAL;
      gr_thirty_one_in          <= LDT_VAL;
      code_segment_app_register <= CODE_VAL;
    end
  end
endmodule // itl_sw_model
`default_nettype wire

// [bench/test_itl_isa_transition.sv]
/*
  Random and corner tests of the transition block.
  Assumes outputs settle one cycle after each request pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module test_itl_isa_transition;
  import itl_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, isa_transfer_intercept_bit = 1'b0;
  logic branch_to_legacy_set = 1'b0, jump_to_native_set = 1'b0, seg_enabled = 1'b1;
  logic seg_default_32 = 1'b1, legacy_fp_fault = 1'b0, legacy_simd_fault = 1'b0;
  logic [63:0] legacy_branch_reg = '0, gr_thirty_in, gr_thirty_one_in;
  logic [31:0] jump_operand = '0, jump_next_ip = '0, legacy_addr = '0;
  logic [31:0] code_segment_app_register, seed = 32'h41E6DAC3;
  logic [1:0]  legacy_mode_sel = '0, legacy_mode, exc_cause;
  logic [6:0]  frame_size;
  logic legacy_active, transfer_intercept, branch_taken, general_register_one_we;
  logic frame_size_clear, stack_engine_enable, speculative_load_table_inval;
  logic native_only_we_block, addr_size_32, exc_valid;
  logic [63:0] branch_target, general_register_one, legacy_vaddr, exc_vector;
  logic [63:0] global_descriptor_table, local_descriptor_table;
  int mismatches = 0, checks = 0;
  always #25 ref_clk = ~ref_clk;
  itl_sw_model sw (.ref_clk, .sys_rst, .gr_thirty_in, .gr_thirty_one_in,
    .code_segment_app_register);
  itl_isa_transition uut (.ref_clk, .sys_rst, .isa_transfer_intercept_bit,
    .branch_to_legacy_set, .legacy_branch_reg, .jump_to_native_set, .jump_operand,
    .jump_next_ip, .code_segment_app_register, .legacy_addr, .seg_enabled,
    .seg_default_32, .legacy_mode_sel, .legacy_fp_fault, .legacy_simd_fault,
    .gr_thirty_in, .gr_thirty_one_in, .legacy_active, .transfer_intercept,
    .branch_taken, .branch_target, .general_register_one_we, .general_register_one,
    .frame_size_clear, .frame_size, .stack_engine_enable, .speculative_load_table_inval,
    .native_only_we_block, .legacy_vaddr, .addr_size_32, .legacy_mode,
    .global_descriptor_table, .local_descriptor_table, .exc_valid, .exc_vector, .exc_cause);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [63:0] jmp_tgt(input logic [31:0] op, input logic [31:0] b);
    return {32'h0000_0000, (op + b) & NATIVE_TGT_MASK};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulse for one cycle; outputs looked at once the answering edge has landed
  // 0 branch, 1 jump, 2 classic fault, other SIMD fault
  task automatic pulse(input int unsigned which);
    @(posedge ref_clk);
    case (which)
      0: branch_to_legacy_set <= 1'b1;
      1: jump_to_native_set <= 1'b1;
      2: legacy_fp_fault <= 1'b1;
      default: legacy_simd_fault <= 1'b1;
    endcase
    @(posedge ref_clk);
    branch_to_legacy_set <= 1'b0;
    jump_to_native_set <= 1'b0;
    legacy_fp_fault <= 1'b0;
    legacy_simd_fault <= 1'b0;
    #1;
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk(legacy_active, 1'b0);
    chk(stack_engine_enable, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      legacy_branch_reg <= {rnd(), rnd()};
      legacy_mode_sel <= 2'(rnd() % 3);
      seg_enabled <= (i % 8 != 6);
      seg_default_32 <= 1'(rnd());
      jump_operand <= (i == 5) ? 32'hFFFF_FFFF : rnd();
      jump_next_ip <= rnd();
      if (i % 4 == 3)
      begin
        isa_transfer_intercept_bit <= 1'b1;
        pulse(0);
        chk(transfer_intercept, 1'b1);
        chk(branch_taken, 1'b0);
        chk(legacy_active, 1'b0);
        isa_transfer_intercept_bit <= 1'b0;
      end
      pulse(0);
      chk(legacy_active, 1'b1);
      chk(branch_taken, 1'b1);
      chk(branch_target, {32'h0000_0000, legacy_branch_reg[31:0]});
      chk(frame_size_clear, 1'b1);
      chk(frame_size, FRAME_ZERO);
      chk(speculative_load_table_inval, 1'b1);
      chk(stack_engine_enable, 1'b0);
      chk(native_only_we_block, 1'b1);
      chk(legacy_mode, legacy_mode_sel);
      chk(global_descriptor_table, gr_thirty_in);
      chk(local_descriptor_table, gr_thirty_one_in);
      chk(addr_size_32, 64'(seg_enabled && seg_default_32));
      pulse(0);
      chk(branch_taken, 1'b0);
      chk(legacy_active, 1'b1);
      legacy_addr <= rnd();
      legacy_simd_fault <= i[0];
      pulse(2);
      chk(legacy_vaddr, {32'h0000_0000, legacy_addr});
      chk(exc_valid, 1'b1);
      chk(exc_vector, VEC_LEGACY_EXC);
      chk(exc_cause, CAUSE_FP_ERR);
      pulse(3);
      chk(exc_cause, CAUSE_SIMD_NUM);
      if (i % 4 == 1)
      begin
        isa_transfer_intercept_bit <= 1'b1;
        pulse(1);
        chk(transfer_intercept, 1'b1);
        chk(branch_taken, 1'b0);
        chk(legacy_active, 1'b1);
        isa_transfer_intercept_bit <= 1'b0;
      end
      pulse(1);
      chk(legacy_active, 1'b0);
      chk(branch_taken, 1'b1);
      chk(branch_target, jmp_tgt(jump_operand, code_segment_app_register));
      chk(general_register_one_we, 1'b1);
      chk(general_register_one, {32'h0000_0000, jump_next_ip});
      chk(stack_engine_enable, 1'b1);
      pulse(1);
      chk(branch_taken, 1'b0);
      chk(legacy_active, 1'b0);
    end
    finish_test();
  end
endmodule // test_itl_isa_transition
`default_nettype wire

// [src/itl_isa_transition.sv]
/*
  Instruction set transition logic: mode flag, branch to the legacy set,
  jump back to the native set, stack frame and load table side effects,
  address zero-extension and legacy float exception vectoring.
  Assumes the pipeline presents one retiring branch per cycle, all on ref_clk.
*/
// Contract
// - Legacy float exceptions vector to offset 6900
// - Classic float errors report legacy float cause
// - SIMD numeric errors report SIMD cause
// - Intercept bit set traps transitions
// - Legacy addresses zero-extend to 64 bits
// - Real, V86, protected; 16/32-bit code
// - Descriptor tables held in general registers
// - Branch target from low 32 bits
// - Branch to legacy zeroes frame size
// - Stack engine disabled while legacy runs
// - Native-only registers left unmodified
// - Legacy execution invalidates load table
// - Jump target is operand plus base, masked
// - Jump targets aligned, below 4 GB
// - Jump writes return address to register one
// - Code base from code segment register
`timescale 1ns/1ps
`default_nettype none
module itl_isa_transition
  import itl_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          isa_transfer_intercept_bit,
  input  wire logic                          branch_to_legacy_set,
  input  wire logic [itl_pkg::ADDR_W-1:0]    legacy_branch_reg,
  input  wire logic                          jump_to_native_set,
  input  wire logic [itl_pkg::LEG_W-1:0]     jump_operand,
  input  wire logic [itl_pkg::LEG_W-1:0]     jump_next_ip,
  input  wire logic [itl_pkg::LEG_W-1:0]     code_segment_app_register,
  input  wire logic [itl_pkg::LEG_W-1:0]     legacy_addr,
  input  wire logic                          seg_enabled,
  input  wire logic                          seg_default_32,
  input  wire logic [1:0]                    legacy_mode_sel,
  input  wire logic                          legacy_fp_fault,
  input  wire logic                          legacy_simd_fault,
  input  wire logic [itl_pkg::ADDR_W-1:0]    gr_thirty_in,
  input  wire logic [itl_pkg::ADDR_W-1:0]    gr_thirty_one_in,
  output logic                               legacy_active,
  output logic                               transfer_intercept,
  output logic                               branch_taken,
  output logic [itl_pkg::ADDR_W-1:0]         branch_target,
  output logic                               general_register_one_we,
  output logic [itl_pkg::ADDR_W-1:0]         general_register_one,
  output logic                               frame_size_clear,
  output logic [6:0]                         frame_size,
  output logic                               stack_engine_enable,
  output logic                               speculative_load_table_inval,
  output logic                               native_only_we_block,
  output logic [itl_pkg::ADDR_W-1:0]         legacy_vaddr,
  output logic                               addr_size_32,
  output logic [1:0]                         legacy_mode,
  output logic [itl_pkg::ADDR_W-1:0]         global_descriptor_table,
  output logic [itl_pkg::ADDR_W-1:0]         local_descriptor_table,
  output logic                               exc_valid,
  output logic [itl_pkg::ADDR_W-1:0]         exc_vector,
  output logic [1:0]                         exc_cause
);
  import itl_pkg::*;

  function automatic logic [ADDR_W-1:0] zext32(input logic [LEG_W-1:0] a);
    zext32 = {{(ADDR_W-LEG_W){1'b0}}, a};
  endfunction

  itl_isa_e          isa_ff;
  itl_isa_e          nxt_isa;
  logic              icpt_ff;
  logic              btk_ff;
  logic [ADDR_W-1:0] tgt_ff;
  logic              g1we_ff;
  logic [ADDR_W-1:0] g1_ff;
  logic              fclr_ff;
  logic [6:0]        fsz_ff;
  logic              inv_ff;
  logic [ADDR_W-1:0] va_ff;
  logic              a32_ff;
  logic [1:0]        lm_ff;
  logic              exv_ff;
  logic [1:0]        exc_ff;

  wire in_legacy  = (isa_ff == ITL_LEGACY);
  wire do_enter   = branch_to_legacy_set && !in_legacy;
  wire do_exit    = jump_to_native_set && in_legacy;
  wire do_icpt    = (do_enter || do_exit) && isa_transfer_intercept_bit;
  wire go_enter   = do_enter && !isa_transfer_intercept_bit;
  wire go_exit    = do_exit && !isa_transfer_intercept_bit;
  wire [LEG_W-1:0] jmp_sum = jump_operand + code_segment_app_register;
  wire [LEG_W-1:0] jmp_tgt = jmp_sum & NATIVE_TGT_MASK;
  wire [LEG_W-1:0] br_tgt  = legacy_branch_reg[LEG_W-1:0];
  wire fp_any   = in_legacy && (legacy_fp_fault || legacy_simd_fault);
  // Classic float error takes priority when both arrive together
  wire [1:0] cause_sel = legacy_fp_fault ? CAUSE_FP_ERR : CAUSE_SIMD_NUM;
  wire [1:0] lm_dec = (legacy_mode_sel == 2'(ITL_V86))  ? 2'(ITL_V86) :
                      (legacy_mode_sel == 2'(ITL_PROT)) ? 2'(ITL_PROT) : 2'(ITL_REAL);

  always_comb
  begin
    nxt_isa = isa_ff;
    if (go_enter)
      nxt_isa = ITL_LEGACY;
    else if (go_exit)
      nxt_isa = ITL_NATIVE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      isa_ff  <= ITL_NATIVE;
      icpt_ff <= 1'b0;
      btk_ff  <= 1'b0;
      tgt_ff  <= '0;
      g1we_ff <= 1'b0;
      g1_ff   <= '0;
      fclr_ff <= 1'b0;
      fsz_ff  <= FRAME_ZERO;
      inv_ff  <= 1'b0;
    end
    else
    begin
      isa_ff  <= nxt_isa;
      icpt_ff <= do_icpt;
      btk_ff  <= go_enter || go_exit;
      if (go_enter)
        tgt_ff <= zext32(br_tgt);
      else if (go_exit)
        tgt_ff <= zext32(jmp_tgt);
      g1we_ff <= go_exit;
      if (go_exit)
        g1_ff <= zext32(jump_next_ip);
      fclr_ff <= go_enter;
      if (go_enter)
        fsz_ff <= FRAME_ZERO;
      inv_ff  <= (nxt_isa == ITL_LEGACY);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      va_ff  <= '0;
      a32_ff <= 1'b0;
      lm_ff  <= 2'(ITL_REAL);
      exv_ff <= 1'b0;
      exc_ff <= CAUSE_NONE;
    end
    else
    begin
      va_ff  <= zext32(legacy_addr);
      a32_ff <= seg_enabled && seg_default_32;
      lm_ff  <= lm_dec;
      exv_ff <= fp_any;
      exc_ff <= fp_any ? cause_sel : CAUSE_NONE;
    end
  end

  assign legacy_active                = in_legacy;
  assign transfer_intercept           = icpt_ff;
  assign branch_taken                 = btk_ff;
  assign branch_target                = tgt_ff;
  assign general_register_one_we      = g1we_ff;
  assign general_register_one         = g1_ff;
  assign frame_size_clear             = fclr_ff;
  assign frame_size                   = fsz_ff;
  assign stack_engine_enable          = !in_legacy;
  assign speculative_load_table_inval = inv_ff;
  // Legacy code may clobber shared registers, never the native-only ones
  assign native_only_we_block         = in_legacy;
  assign legacy_vaddr                 = va_ff;
  assign addr_size_32                 = a32_ff;
  assign legacy_mode                  = lm_ff;
  // Descriptor tables live in ordinary registers, hence no protection here
  assign global_descriptor_table      = gr_thirty_in;
  assign local_descriptor_table       = gr_thirty_one_in;
  assign exc_valid                    = exv_ff;
  assign exc_vector                   = VEC_LEGACY_EXC;
  assign exc_cause                    = exc_ff;

  // Transition steps: request edge, then the answering edge
  sequence seq_enter_req;
    go_enter;
  endsequence
  sequence seq_enter_done;
    legacy_active && branch_taken && frame_size_clear;
  endsequence

  sequence seq_exit_req;
    go_exit;
  endsequence
  sequence seq_exit_done;
    !legacy_active && branch_taken && general_register_one_we;
  endsequence

  sequence seq_icpt_req;
    do_icpt;
  endsequence
  sequence seq_icpt_done;
    transfer_intercept && !branch_taken;
  endsequence

  chk_enter_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seq_enter_req |=> seq_enter_done)
    else $error("enter not taken");

  chk_exit_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seq_exit_req |=> seq_exit_done)
    else $error("exit not taken");

  chk_intercept_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seq_icpt_req |=> seq_icpt_done ##0 $stable(legacy_active))
    else $error("intercept leak");

  // Mode may only move on a retiring transition, never on its own
  chk_mode_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !go_enter && !go_exit |=> $stable(legacy_active))
    else $error("mode moved");

  chk_ignore_enter: assert property (@(posedge ref_clk) disable iff (sys_rst)
    branch_to_legacy_set && in_legacy && !jump_to_native_set |=> legacy_active && !branch_taken)
    else $error("enter while legacy");

  chk_ignore_exit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    jump_to_native_set && !in_legacy && !branch_to_legacy_set |=> !legacy_active && !branch_taken)
    else $error("exit while native");

  chk_jump_target: assert property (@(posedge ref_clk) disable iff (sys_rst)
    go_exit |=> branch_target[3:0] == 4'h0 && branch_target[63:32] == 32'h0)
    else $error("bad jump target");

  chk_jump_sum: assert property (@(posedge ref_clk) disable iff (sys_rst)
    go_exit |=> branch_target[31:0] ==
      (($past(jump_operand) + $past(code_segment_app_register)) & NATIVE_TGT_MASK))
    else $error("bad jump sum");

  chk_ret_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    go_exit |=> general_register_one_we && general_register_one[31:0] == $past(jump_next_ip)
      && general_register_one[63:32] == 32'h0)
    else $error("bad return address");

  chk_gr1_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !go_exit |=> !general_register_one_we)
    else $error("stray register write");

  chk_frame_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    go_enter |=> frame_size_clear && frame_size == FRAME_ZERO)
    else $error("frame not zeroed");

  chk_rse_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    legacy_active |-> !stack_engine_enable)
    else $error("stack engine on");

  chk_rse_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !legacy_active |-> stack_engine_enable)
    else $error("stack engine off");

  chk_slt_inval: assert property (@(posedge ref_clk) disable iff (sys_rst)
    legacy_active |-> speculative_load_table_inval)
    else $error("table not invalidated");

  chk_native_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
    legacy_active |-> native_only_we_block)
    else $error("native regs open");

  chk_fp_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_legacy && legacy_fp_fault |=> exc_valid && exc_cause == CAUSE_FP_ERR)
    else $error("fp cause");

  chk_simd_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_legacy && legacy_simd_fault && !legacy_fp_fault |=> exc_cause == CAUSE_SIMD_NUM)
    else $error("simd cause");

  chk_exc_vector: assert property (@(posedge ref_clk) disable iff (sys_rst)
    exc_valid |-> exc_vector == VEC_LEGACY_EXC)
    else $error("bad vector");

  // Native faults belong to other vectors, so nothing may leak out here
  chk_native_no_exc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !in_legacy |=> !exc_valid)
    else $error("native fault vectored");

  chk_zext_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> legacy_vaddr == {32'h0, $past(legacy_addr)})
    else $error("no zero extend");

  chk_branch_tgt: assert property (@(posedge ref_clk) disable iff (sys_rst)
    go_enter |=> branch_target == {32'h0, $past(legacy_branch_reg[31:0])})
    else $error("bad branch target");

  chk_mode_sel: assert property (@(posedge ref_clk) disable iff (sys_rst)
    legacy_mode_sel == 2'(ITL_PROT) |=> legacy_mode == 2'(ITL_PROT))
    else $error("mode sel");

  chk_addr_size: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seg_enabled && seg_default_32 |=> addr_size_32)
    else $error("not 32-bit code");

  chk_addr_16: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(seg_enabled && seg_default_32) |=> !addr_size_32)
    else $error("not 16-bit code");

  chk_desc_regs: assert property (@(posedge ref_clk) disable iff (sys_rst)
    global_descriptor_table == gr_thirty_in && local_descriptor_table == gr_thirty_one_in)
    else $error("descriptor mismatch");

endmodule // itl_isa_transition
`default_nettype wire

// [src/itl_pkg.sv]
/*
  Constants shared by the instruction set transition block.
  Assumes a core pipeline that presents retiring transition branches.
*/
`default_nettype none
package itl_pkg;
  localparam int          ADDR_W          = 64;
  localparam int          LEG_W           = 32;
  localparam logic [63:0] VEC_LEGACY_EXC  = 64'h0000_0000_0000_6900;
  localparam logic [31:0] NATIVE_TGT_MASK = 32'hFFFF_FFF0;
  localparam logic [6:0]  FRAME_ZERO      = 7'h00;
  localparam logic [1:0]  CAUSE_NONE      = 2'h0;
  localparam logic [1:0]  CAUSE_FP_ERR    = 2'h1;
  localparam logic [1:0]  CAUSE_SIMD_NUM  = 2'h2;
  localparam int          SLT_ENTRIES     = 8;
  typedef enum logic [1:0] { ITL_REAL, ITL_V86, ITL_PROT } itl_legacy_mode_e;
  typedef enum { ITL_NATIVE, ITL_LEGACY } itl_isa_e;
endpackage
`default_nettype wire
